// *** rtl/port_a_pin_control.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port a pin control: registers, pad drive, pin sampling
// ----------------------------------------------------------------
module port_a_pin_control
    import port_a_pkg::*;
(
    input  wire logic        sys_clk,        // 40 MHz system clock
    input  wire logic        srst,           // sync reset, high
    input  wire logic        ce,             // clock enable
    input  wire logic [31:0] s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // byte strobes
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [31:0] s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready,   // read data ready
    input  wire logic [7:0]  pad_in,         // pin levels
    output logic      [7:0]  pad_out,        // pin drive levels
    output logic      [7:0]  pad_oe          // pin drive enables
);
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum {
        SEL_PIN,    // port_pin_state
        SEL_LATCH,  // port_output_latch
        SEL_DIR,    // port_direction
        SEL_ANA,    // analog_pin_select_0
        SEL_CTL,    // function control
        SEL_NONE    // unmapped
    } reg_sel_t;

    typedef struct packed {
        logic [7:0]            latch;    // output latch
        logic [7:0]            dir;      // direction, one = input
        logic [7:0]            ansel;    // analog select, zero = analog
        ctrl_t                 ctrl;     // function control
        logic [7:0]            pins;     // sampled pad levels
        logic [7:0]            pad_out;  // registered pad levels
        logic [7:0]            pad_oe;   // registered pad enables
        logic [CYCLE_CLOCK_OUT_DIV_W-1:0] div;      // cycle clock divider
    } core_state_t;

    core_state_t st_q;    // registered state
    core_state_t st_d;    // next state
    logic [7:0]  out_d;   // mux pad level
    logic [7:0]  oe_d;    // mux pad enable
    logic [7:0]  in_en;   // digital inputs open
    reg_bus_if   bus ();  // slave to core strobes

    // address to register decode, shared by read and write
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        if (a == OFS_PIN_STATE) begin
            return SEL_PIN;
        end else if (a == OFS_OUTPUT_LATCH) begin
            return SEL_LATCH;
        end else if (a == OFS_DIRECTION) begin
            return SEL_DIR;
        end else if (a == OFS_ANALOG_SEL) begin
            return SEL_ANA;
        end else if (a == OFS_CONTROL) begin
            return SEL_CTL;
        end else begin
            return SEL_NONE;
        end
    endfunction

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    axil_reg_slave u_slave (
        .sys_clk       (sys_clk),
        .srst          (srst),
        .ce            (ce),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .bus           (bus)
    );

    // ----------------------------------------------------------------
    // pin function selection
    // ----------------------------------------------------------------
    pin_mux u_mux (
        .latch   (st_q.latch),
        .dir     (st_q.dir),
        .ansel   (st_q.ansel),
        .ctrl    (st_q.ctrl),
        .cyc_clk (st_q.div[CYCLE_CLOCK_OUT_DIV_W-1]),
        .out_d   (out_d),
        .oe_d    (oe_d),
        .in_en   (in_en)
    );

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    always_comb begin
        bus.rd_err = 1'b0;
        case (decode(bus.rd_addr))
            SEL_PIN: begin
                // sampled pins, closed inputs read zero
                bus.rd_data = st_q.pins & in_en;  // see R11 see R12 see R09
            end
            SEL_LATCH: begin
                bus.rd_data = st_q.latch;  // see R13
            end
            SEL_DIR: begin
                bus.rd_data = st_q.dir;
            end
            SEL_ANA: begin
                bus.rd_data = st_q.ansel;
            end
            SEL_CTL: begin
                bus.rd_data = {5'h00, st_q.ctrl};
            end
            default: begin
                bus.rd_data = 8'h00;
                bus.rd_err  = 1'b1;
            end
        endcase
    end

    assign bus.wr_err = (decode(bus.wr_addr) == SEL_NONE);

    // ----------------------------------------------------------------
    // next state: writes, pin sampling, pad drive, divider
    // ----------------------------------------------------------------
    always_comb begin
        st_d         = st_q;
        st_d.pins    = pad_in;
        st_d.pad_out = out_d;
        st_d.pad_oe  = oe_d;
        st_d.div     = st_q.div + CYCLE_CLOCK_OUT_DIV_W'(1);
        if (bus.wr_en) begin
            case (decode(bus.wr_addr))
                SEL_PIN, SEL_LATCH: begin
                    // port write lands in the latch
                    st_d.latch = bus.wr_data & IMPL_MASK;  // see R11 see R09
                end
                SEL_DIR: begin
                    st_d.dir = bus.wr_data & IMPL_MASK;  // see R09
                end
                SEL_ANA: begin
                    st_d.ansel = bus.wr_data;
                end
                SEL_CTL: begin
                    st_d.ctrl = bus.wr_data[2:0];
                end
                default: begin
                    st_d.latch = st_q.latch;  // unmapped: no effect
                end
            endcase
        end
    end

    // state register; reset wins over ce
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q       <= '0;
            st_q.latch <= RST_LATCH;
            st_q.dir   <= RST_DIRECTION;
            st_q.ansel <= RST_ANALOG_SEL;  // see R06 see R12
            st_q.ctrl  <= RST_CONTROL;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign pad_out = st_q.pad_out;
    assign pad_oe  = st_q.pad_oe;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_comparator_ref_out_pad_off: assert property (  // see R01
        (ce && st_q.ctrl.comparator_ref_out_en) |=> (!pad_oe[PIN_COMPARATOR_REF_OUT] && !pad_out[PIN_COMPARATOR_REF_OUT])
    ) else $error("pin two driven while reference output on");

    a_pin2_input_gate: assert property (  // see R02
        (st_q.ctrl.comparator_ref_out_en || st_q.ctrl.cmp2_en || !st_q.ansel[2])
            |-> (!in_en[2] && (decode(bus.rd_addr) != SEL_PIN || !bus.rd_data[2]))
    ) else $error("pin two input open while analog in use");

    a_pin35_input_gate: assert property (  // see R03
        (!st_q.ansel[3] |-> !in_en[3]) and (!st_q.ansel[4] |-> !in_en[5])
    ) else $error("analog pin input not closed");

    a_pin3_latch_out: assert property (  // see R04
        (ce && !st_q.dir[3]) |=> (pad_oe[3] && pad_out[3] == $past(st_q.latch[3]))
    ) else $error("pin three not driven from latch");

    a_pin5_latch_out: assert property (  // see R05
        (ce && !st_q.dir[5]) |=> (pad_oe[5] && pad_out[5] == $past(st_q.latch[5]))
    ) else $error("pin five not driven from latch");

    a_reset_analog: assert property (  // see R06
        $fell(srst) |-> (st_q.ansel == RST_ANALOG_SEL && !in_en[5] && !in_en[0])
    ) else $error("pins not analog after reset");

    a_cycle_clock: assert property (  // see R07
        (ce && st_q.ctrl.cycle_clock_out_en) |=> (pad_out[PIN_CYCLE_CLOCK_OUT] == $past(st_q.div[CYCLE_CLOCK_OUT_DIV_W-1]))
    ) else $error("cycle clock not on pin six");

    a_owned_dir: assert property (  // see R08
        (ce && st_q.ctrl.cycle_clock_out_en && st_q.dir[PIN_CYCLE_CLOCK_OUT]) |=> pad_oe[PIN_CYCLE_CLOCK_OUT]
    ) else $error("pin six direction not overridden");

    // analog select keeps its bit four for pin five, so its reads are exempt
    a_bit4_zero: assert property (  // see R09
        (decode(bus.rd_addr) == SEL_ANA || !bus.rd_data[PIN_UNBUILT])
            && !pad_oe[PIN_UNBUILT] && !st_q.dir[PIN_UNBUILT] && !st_q.latch[PIN_UNBUILT]
    ) else $error("bit four not zero");

    a_dir_hiz: assert property (  // see R10
        (ce && st_q.dir[0]) |=> !pad_oe[0]
    ) else $error("input pin still driven");

    a_port_write: assert property (  // see R11
        (ce && bus.wr_en && decode(bus.wr_addr) == SEL_PIN)
            |=> (st_q.latch == ($past(bus.wr_data) & IMPL_MASK))
    ) else $error("port write did not reach latch");

    a_latch_read: assert property (  // see R13
        (decode(bus.rd_addr) == SEL_LATCH) |-> (bus.rd_data == st_q.latch)
    ) else $error("latch read not from latch");

    c_comparator_ref_out_on: cover property (ce && st_q.ctrl.comparator_ref_out_en && !st_q.dir[2]);
    c_cycle_clock_out_on: cover property (ce && st_q.ctrl.cycle_clock_out_en ##1 pad_out[PIN_CYCLE_CLOCK_OUT]);
    c_port_write: cover property (bus.wr_en && decode(bus.wr_addr) == SEL_PIN);
    c_digital_read: cover property (st_q.ansel[4] && !st_q.dir[5] ##1 s_axi_rvalid);
endmodule

// *** rtl/port_a_pkg.sv ***
// Operation
// R01 - reference output disables pin two digital path
// R02 - pin two input off while analog used
// R03 - pins three, five input off when analog
// R04 - pin three output follows latch, not analog
// R05 - pin five output follows latch always
// R06 - pin five powers up as analog channel
// R07 - cycle clock modes drive quarter-rate clock on six
// R08 - owned pins ignore their direction bit
// R09 - bit four reads zero in all registers; analog select stores and returns its bit four, for pin five
// R10 - direction one floats pin, zero drives latch
// R11 - port reads pins, port write sets latch
// R12 - analog pins power up reading zero
// R13 - latch read returns stored latch value
package port_a_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W           = 8;      // decoded address bits
    localparam logic [7:0]  OFS_PIN_STATE    = 8'h00;  // port_pin_state
    localparam logic [7:0]  OFS_OUTPUT_LATCH = 8'h04;  // port_output_latch
    localparam logic [7:0]  OFS_DIRECTION    = 8'h08;  // port_direction
    localparam logic [7:0]  OFS_ANALOG_SEL   = 8'h0C;  // analog_pin_select_0
    localparam logic [7:0]  OFS_CONTROL      = 8'h10;  // pin function control

    // ----------------------------------------------------------------
    // field layouts and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  IMPL_MASK        = 8'hEF;  // bit 4 not built
    localparam logic [7:0]  ANALOG_PINS      = 8'h2F;  // pins with an analog input
    localparam logic [7:0]  RST_LATCH        = 8'h00;  // latch after reset
    localparam logic [7:0]  RST_DIRECTION    = 8'hEF;  // all pins inputs
    localparam logic [7:0]  RST_ANALOG_SEL   = 8'h00;  // zero bit = analog pin
    localparam logic [2:0]  RST_CONTROL      = 3'h0;   // no function owns a pin
    localparam int unsigned CTL_CYCLE_CLOCK_OUT_BIT     = 2;      // cycle_clock_out enable
    localparam int unsigned CTL_CMP2_BIT     = 1;      // comparator inputs on pin two
    localparam int unsigned CTL_COMPARATOR_REF_OUT_BIT    = 0;      // comparator_ref_out enable
    localparam int unsigned PIN_COMPARATOR_REF_OUT        = 2;      // pin_two
    localparam int unsigned PIN_UNBUILT      = 4;      // missing bit
    localparam int unsigned PIN_CYCLE_CLOCK_OUT         = 6;      // pin_six

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CYCLE_CLOCK_OUT_DIV         = 4;      // sys clocks per cycle clock
    localparam int unsigned CYCLE_CLOCK_OUT_DIV_W       = $clog2(CYCLE_CLOCK_OUT_DIV);

    // ----------------------------------------------------------------
    // bus answers
    // ----------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY        = 2'h0;   // access done
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;   // unmapped address

    // pin function control fields
    typedef struct packed {
        logic cycle_clock_out_en;   // cycle clock on pin six
        logic cmp2_en;   // comparator inputs on pin two
        logic comparator_ref_out_en;  // reference output on pin two
    } ctrl_t;

endpackage

// *** rtl/reg_bus_if.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// register strobes between bus slave and port core
// ----------------------------------------------------------------
interface reg_bus_if;
    import port_a_pkg::*;
    logic              wr_en;    // one-cycle write strobe
    logic [ADDR_W-1:0] wr_addr;  // write address
    logic [7:0]        wr_data;  // write data, low byte
    logic              wr_err;   // write address unmapped
    logic [ADDR_W-1:0] rd_addr;  // read address
    logic [7:0]        rd_data;  // read data
    logic              rd_err;   // read address unmapped

    modport slave (output wr_en, wr_addr, wr_data, rd_addr,
                   input  wr_err, rd_data, rd_err);
    modport core  (input  wr_en, wr_addr, wr_data, rd_addr,
                   output wr_err, rd_data, rd_err);
endinterface

// *** rtl/axil_reg_slave.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// axi4-lite slave, one write and one read in flight
// ----------------------------------------------------------------
module axil_reg_slave
    import port_a_pkg::*;
(
    input  wire logic        sys_clk,        // system clock
    input  wire logic        srst,           // sync reset
    input  wire logic        ce,             // clock enable
    input  wire logic [31:0] s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // byte strobes
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [31:0] s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready,   // read data ready
    reg_bus_if.slave         bus             // register strobes
);
    typedef struct packed {
        logic              aw_free;  // address slot empty
        logic [ADDR_W-1:0] aw_addr;  // held write address
        logic              w_free;   // data slot empty
        logic [7:0]        w_data;   // held write byte
        logic              w_be0;    // low lane enabled
        logic              bvalid;   // response pending
        logic [1:0]        bresp;    // response code
        logic              ar_free;  // read slot empty
        logic              rvalid;   // read data pending
        logic [7:0]        rdata;    // read byte
        logic [1:0]        rresp;    // read code
    } slv_state_t;

    slv_state_t st_q;  // registered state
    slv_state_t st_d;  // next state

    // handshakes, write strobe and read capture
    always_comb begin
        st_d        = st_q;
        bus.wr_en   = 1'b0;
        bus.wr_addr = st_q.aw_addr;
        bus.wr_data = st_q.w_data;
        bus.rd_addr = s_axi_araddr[ADDR_W-1:0];
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (s_axi_awvalid && st_q.aw_free) begin
            st_d.aw_free = 1'b0;
            st_d.aw_addr = s_axi_awaddr[ADDR_W-1:0];
        end
        if (s_axi_wvalid && st_q.w_free) begin
            st_d.w_free = 1'b0;
            st_d.w_data = s_axi_wdata[7:0];
            st_d.w_be0  = s_axi_wstrb[0];
        end
        // both halves held: commit and answer next edge
        if (!st_q.aw_free && !st_q.w_free && !st_q.bvalid) begin
            bus.wr_en    = st_q.w_be0;
            st_d.aw_free = 1'b1;
            st_d.w_free  = 1'b1;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = bus.wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid  = 1'b0;
            st_d.ar_free = 1'b1;
        end
        if (s_axi_arvalid && st_q.ar_free) begin
            st_d.ar_free = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rdata   = bus.rd_err ? 8'h00 : bus.rd_data;
            st_d.rresp   = bus.rd_err ? RESP_SLVERR : RESP_OKAY;
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q         <= '0;
            st_q.aw_free <= 1'b1;
            st_q.w_free  <= 1'b1;
            st_q.ar_free <= 1'b1;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready = st_q.aw_free;
    assign s_axi_wready  = st_q.w_free;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = st_q.ar_free;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rresp   = st_q.rresp;
    assign s_axi_rdata   = {{24{1'b0}}, st_q.rdata};
endmodule

// *** rtl/pin_mux.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// per-pin output, enable and input-gate selection
// ----------------------------------------------------------------
module pin_mux
    import port_a_pkg::*;
(
    input  wire logic [7:0] latch,    // port_output_latch
    input  wire logic [7:0] dir,      // port_direction
    input  wire logic [7:0] ansel,    // analog_pin_select_0
    input  wire ctrl_t      ctrl,     // function control
    input  wire logic       cyc_clk,  // quarter-rate clock
    output logic      [7:0] out_d,    // next pad level
    output logic      [7:0] oe_d,     // next pad enable
    output logic      [7:0] in_en     // digital input open
);
    // analog select bit that serves a pin: pin five uses bit four
    function automatic int unsigned pin_analog_cfg_of(input int unsigned pin);
        return (pin > 4) ? pin - 1 : pin;
    endfunction

    // ----------------------------------------------------------------
    // one selector per pin
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_pin
        logic an_on;  // pin taken as analog input
        always_comb begin
            an_on    = ANALOG_PINS[i] && !ansel[pin_analog_cfg_of(i)];
            // input gate: analog and pin-two functions close it
            in_en[i] = IMPL_MASK[i] && !an_on;  // see R02 see R03 see R12
            if (i == PIN_COMPARATOR_REF_OUT && (ctrl.comparator_ref_out_en || ctrl.cmp2_en)) begin
                in_en[i] = 1'b0;  // see R01 see R02
            end
            // output: analog select never touches the digital driver
            out_d[i] = latch[i];  // see R04 see R05
            oe_d[i]  = !dir[i];   // see R10
            if (!IMPL_MASK[i]) begin
                out_d[i] = 1'b0;
                oe_d[i]  = 1'b0;
            end else if (i == PIN_CYCLE_CLOCK_OUT && ctrl.cycle_clock_out_en) begin
                out_d[i] = cyc_clk;  // see R07
                oe_d[i]  = 1'b1;     // see R08
            end else if (i == PIN_COMPARATOR_REF_OUT && ctrl.comparator_ref_out_en) begin
                out_d[i] = 1'b0;
                oe_d[i]  = 1'b0;     // see R01 see R08
            end
        end
    end
endmodule

// *** test/pin_partner.sv ***
`timescale 1ns/1ps
// far side: device drive wins, released pins show ext
module pin_partner (
    input  wire logic [7:0] pad_out,  // device level
    input  wire logic [7:0] pad_oe,   // device enable
    input  wire logic [7:0] ext,      // outside level
    output logic      [7:0] pad_in    // pin level
);
    // ext is re-randomised, so a stale level cannot pass
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule

// *** test/tb_port_a_pin_control.sv ***
`timescale 1ns/1ps
module tb_port_a_pin_control;
    import port_a_pkg::*;
    logic        sys_clk = 0, srst = 1, ce = 1;  // clock, reset, enable
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1;             // low byte only
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [7:0]  pad_in, pad_out, pad_oe, ext = 0;
    logic [7:0]  lat = 0, dir = 8'hEF, ans = 0, ctl = 0;  // register model
    logic [31:0] rd;
    int          n_mismatch = 0, samples_checked = 0, seed = 45017, k, cnt;
    port_a_pin_control i_port_a_pin_control (.sys_clk, .srst, .ce, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pad_in, .pad_out, .pad_oe);
    pin_partner i_pin_partner (.pad_out, .pad_oe, .ext, .pad_in);
    always #12.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one bus access; holds each valid until its ready, waits bounded
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
        int i;
        @(posedge sys_clk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_araddr <= {24'h0, a};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid | s_axi_rvalid) break;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        rs = w ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        if (i == 40) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    // write and mirror into the model
    task automatic wrm(input logic [7:0] a, input logic [7:0] v);
        xfer(1'b1, a, v);
        case (a)
            8'h00, 8'h04: lat = v & 8'hEF;
            8'h08: dir = v & 8'hEF;
            8'h0C: ans = v;
            8'h10: ctl = v & 8'h07;
            default: ;
        endcase
        chk(rs, a > 8'h10 ? RESP_SLVERR : RESP_OKAY);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(rs, a > 8'h10 ? RESP_SLVERR : RESP_OKAY);
        chk(rd, {24'h0, e});
    endtask
    // model drive enables and open digital inputs
    function automatic logic [7:0] oem();
        logic [7:0] o;
        o = ~dir & 8'hEF;
        if (ctl[0]) o[2] = 1'b0;
        if (ctl[2]) o[6] = 1'b1;
        return o;
    endfunction
    function automatic logic [7:0] pins();
        logic [7:0] m;
        m = {2'b11, ans[4], 1'b0, ans[3:0]};
        if (ctl[0] | ctl[1]) m[2] = 1'b0;
        return m & ((ext & ~oem()) | (lat & oem()));
    endfunction
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        ext <= 8'($random(seed));
        rdm(8'h04, 8'h00);
        rdm(8'h08, 8'hEF);
        rdm(8'h0C, 8'h00);
        rdm(8'h00, pins());
        $display("reset test done");
        for (k = 0; k < 24; k++) begin
            ext <= 8'($random(seed));
            wrm(k % 2 ? 8'h00 : 8'h04, 8'($random(seed)));
            wrm(8'h08, 8'($random(seed)));
            wrm(8'h0C, 8'($random(seed)));
            wrm(8'h10, 8'($random(seed)) & 8'h03);
            rdm(8'h00, pins());
            rdm(8'h04, lat);
            chk(pad_oe, oem());
            chk(pad_out & oem(), lat & oem());
        end
        $display("pin mux test done");
        wrm(8'h10, 8'h04);
        wrm(8'h08, 8'hFF);
        cnt = 0;
        repeat (8) @(posedge sys_clk) cnt += pad_out[6];
        chk(cnt, 4);
        chk(pad_oe[6], 1'b1);
        $display("cycle clock test done");
        wrm(8'h04, 8'hFF);
        rdm(8'h04, 8'hEF);
        rdm(8'h08, 8'hEF);
        wrm(8'h14, 8'h55);
        rdm(8'h14, 8'h00);
        $display("bit four and unmapped test done");
        give_verdict();
    end
endmodule
